// ==== hdl/lwd_defs.svh ====
// constants shared by both ends of the write-only two-wire link
// assumes a 125 MHz system clock on both ends
`ifndef LWD_DEFS_SVH
`define LWD_DEFS_SVH
`define LWD_SLAVE_ADDR  7'h1b
`define LWD_REG_RESET   8'h00
`define LWD_NUM_REGS    7
`define LWD_SUB_BITS    3
`define LWD_FILT_LEN    3
`define LWD_CLK_NS      8
`define LWD_SCL_MIN_NS  2500
`define LWD_QTR_CYC     ((`LWD_SCL_MIN_NS / 4 + `LWD_CLK_NS - 1) / `LWD_CLK_NS)
`define LWD_FIFO_DEPTH  8
`endif

// ==== hdl/lwd_fifo.sv ====
// small synchronous fifo with valid/ready on both sides
// assumes one clock; full and empty follow the word count exactly
`timescale 1ns/1ns
`default_nettype none
module lwd_fifo #(
   parameter int W     = 16,
   parameter int DEPTH = 8
) (
   // clock and reset
   input  wire logic         clk,
   input  wire logic         rst_n,
   // fill side
   input  wire logic         in_valid,
   output logic              in_ready,
   input  wire logic [W-1:0] in_data,
   // drain side
   output logic              out_valid,
   input  wire logic         out_ready,
   output logic [W-1:0]      out_data
);
   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   logic [W-1:0]  mem [DEPTH];
   logic [AW-1:0] wr_ptr_reg;
   logic [AW-1:0] rd_ptr_reg;
   logic [AW:0]   count_reg;
   logic          push;
   logic          pop;

   assign in_ready  = (count_reg != (AW+1)'(DEPTH));
   assign out_valid = (count_reg != '0);
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;
   assign out_data  = mem[rd_ptr_reg];

   always_ff @(posedge clk) begin
      if (push) begin
         mem[wr_ptr_reg] <= in_data;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
         count_reg  <= '0;
      end else begin
         if (push) begin
            wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH - 1)) ? '0 : wr_ptr_reg + 1'b1;
         end
         if (pop) begin
            rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH - 1)) ? '0 : rd_ptr_reg + 1'b1;
         end
         count_reg <= count_reg + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule : lwd_fifo
`default_nettype wire

// ==== hdl/lwd_host_end.sv ====
// bus master end: drains queued sub-address/data words onto the bus
// assumes the slave never stretches the clock
`timescale 1ns/1ns
`include "lwd_defs.svh"
`default_nettype none
module lwd_host_end
   import lwd_pkg::*;
#(
   parameter int DEPTH = `LWD_FIFO_DEPTH,
   parameter int QTR   = `LWD_QTR_CYC
) (
   // clock and reset
   input  wire logic       CLOCK,
   input  wire logic       RSTN,
   // two-wire bus
   lwd_if.master           BUS,
   // write words
   input  wire logic       WR_VALID,
   output logic            WR_READY,
   input  wire logic [7:0] WR_SUB,
   input  wire logic [7:0] WR_DATA,
   // transfer setup
   input  wire logic [6:0] TARGET_ADDR,
   input  wire logic       DIR_READ,
   // status
   output logic            BUSY,
   output logic            NACK
);
   localparam int QW = $clog2(QTR + 1);

   logic            f_valid;
   logic            f_pop;
   logic [15:0]     f_word;
   logic [1:0]      sda_sync_reg;
   lwd_host_state_t state_reg;
   lwd_kind_t       kind_reg;
   logic [QW-1:0]   qcnt_reg;
   logic            tick;
   logic [1:0]      phase_reg;
   logic [3:0]      bit_reg;
   logic [8:0]      shift_reg;
   logic [15:0]     word_reg;
   logic            ack_ok_reg;
   logic            scl_low_reg;
   logic            sda_low_reg;
   logic            nack_reg;
   logic            byte_done;
   logic            more;

   lwd_fifo #(.W(16), .DEPTH(DEPTH)) u_fifo (
      .clk       (CLOCK),
      .rst_n     (RSTN),
      .in_valid  (WR_VALID),
      .in_ready  (WR_READY),
      .in_data   ({WR_SUB, WR_DATA}),
      .out_valid (f_valid),
      .out_ready (f_pop),
      .out_data  (f_word)
   );

   always_ff @(posedge CLOCK or negedge RSTN) begin
      if (!RSTN) begin
         sda_sync_reg <= 2'h3;
      end else begin
         sda_sync_reg <= {sda_sync_reg[0], BUS.sda};
      end
   end

   // quarter-bit timebase, rounded up so scl never beats 400 kHz
   always_ff @(posedge CLOCK or negedge RSTN) begin
      if (!RSTN) begin
         qcnt_reg <= '0;
      end else begin
         qcnt_reg <= (tick || state_reg == HS_IDLE) ? '0 : qcnt_reg + 1'b1;
      end
   end
   assign tick = (qcnt_reg == QW'(QTR - 1));

   assign byte_done = tick && (state_reg == HS_BIT) && (phase_reg == 2'h3) && (bit_reg == 4'h8);
   assign more      = ack_ok_reg && !sda_sync_reg[1];
   assign f_pop     = f_valid && ((state_reg == HS_IDLE) || (byte_done && kind_reg == BK_DATA && more));

   always_ff @(posedge CLOCK or negedge RSTN) begin
      if (!RSTN) begin
         state_reg   <= HS_IDLE;
         kind_reg    <= BK_ADDR;
         phase_reg   <= 2'h0;
         bit_reg     <= 4'h0;
         shift_reg   <= 9'h1ff;
         word_reg    <= 16'h0000;
         ack_ok_reg  <= 1'b0;
         scl_low_reg <= 1'b0;
         sda_low_reg <= 1'b0;
         nack_reg    <= 1'b0;
      end else begin
         nack_reg <= 1'b0;
         case (state_reg)
            HS_IDLE: begin
               if (f_valid) begin
                  word_reg  <= f_word;
                  shift_reg <= {TARGET_ADDR, DIR_READ, 1'b1};
                  kind_reg  <= BK_ADDR;
                  state_reg <= HS_START;
                  phase_reg <= 2'h0;
               end
            end
            HS_START: begin
               if (tick) begin
                  phase_reg <= phase_reg + 2'h1;
                  if (phase_reg == 2'h0) begin
                     sda_low_reg <= 1'b1;
                  end else if (phase_reg == 2'h1) begin
                     scl_low_reg <= 1'b1;
                     state_reg   <= HS_BIT;
                     phase_reg   <= 2'h0;
                     bit_reg     <= 4'h0;
                  end
               end
            end
            HS_BIT: begin
               if (tick) begin
                  phase_reg <= phase_reg + 2'h1;
                  case (phase_reg)
                     2'h0: sda_low_reg <= !shift_reg[8];
                     2'h1: scl_low_reg <= 1'b0;
                     2'h2: ack_ok_reg  <= (bit_reg == 4'h8);
                     default: begin
                        scl_low_reg <= 1'b1;
                        shift_reg   <= {shift_reg[7:0], 1'b1};
                        bit_reg     <= bit_reg + 4'h1;
                        if (bit_reg == 4'h8) begin
                           bit_reg <= 4'h0;
                           if (!more) begin
                              nack_reg  <= 1'b1;
                              state_reg <= HS_STOP;
                           end else if (kind_reg == BK_ADDR || kind_reg == BK_DATA) begin
                              if (kind_reg == BK_DATA && !f_valid) begin
                                 state_reg <= HS_STOP;
                              end else begin
                                 if (kind_reg == BK_DATA) begin
                                    word_reg <= f_word;
                                 end
                                 shift_reg <= {(kind_reg == BK_DATA) ? f_word[15:8] : word_reg[15:8], 1'b1};
                                 kind_reg  <= BK_SUB;
                              end
                           end else begin
                              shift_reg <= {word_reg[7:0], 1'b1};
                              kind_reg  <= BK_DATA;
                           end
                        end
                     end
                  endcase
               end
            end
            HS_STOP: begin
               if (tick) begin
                  phase_reg <= phase_reg + 2'h1;
                  case (phase_reg)
                     2'h0: sda_low_reg <= 1'b1;
                     2'h1: scl_low_reg <= 1'b0;
                     2'h2: sda_low_reg <= 1'b0;
                     default: state_reg <= HS_IDLE;
                  endcase
               end
            end
            default: begin
               state_reg <= HS_IDLE;
            end
         endcase
      end
   end

   assign BUS.m_scl_o  = 1'b0;
   assign BUS.m_scl_oe = scl_low_reg;
   assign BUS.m_sda_o  = 1'b0;
   assign BUS.m_sda_oe = sda_low_reg;
   assign BUSY         = (state_reg != HS_IDLE);
   assign NACK         = nack_reg;
endmodule : lwd_host_end
`default_nettype wire

// ==== hdl/lwd_if.sv ====
// open-drain two-wire bus joining host end and device end
// both lines are pulled high when nobody drives them low
`timescale 1ns/1ns
`default_nettype none
interface lwd_if;
   logic m_scl_o;
   logic m_scl_oe;
   logic m_sda_o;
   logic m_sda_oe;
   logic s_sda_o;
   logic s_sda_oe;
   logic scl;
   logic sda;
   assign scl = !(m_scl_oe && !m_scl_o);
   assign sda = !((m_sda_oe && !m_sda_o) || (s_sda_oe && !s_sda_o));
   modport master (output m_scl_o, output m_scl_oe, output m_sda_o, output m_sda_oe, input scl, input sda);
   modport slave  (output s_sda_o, output s_sda_oe, input scl, input sda);
endinterface : lwd_if
`default_nettype wire

// ==== hdl/lwd_pkg.sv ====
// types shared by both ends of the write-only two-wire link
// assumes lwd_defs.svh is on the include path
`default_nettype none
package lwd_pkg;
   typedef enum logic [1:0] {BK_ADDR, BK_SUB, BK_DATA} lwd_kind_t;
   typedef enum logic [1:0] {SS_IDLE, SS_BITS, SS_ACK, SS_SKIP} lwd_slave_state_t;
   typedef enum logic [1:0] {HS_IDLE, HS_START, HS_BIT, HS_STOP} lwd_host_state_t;
endpackage : lwd_pkg
`default_nettype wire

// ==== hdl/lwd_slave_end.sv ====
// write-only two-wire slave with holding latches and stop-time update
// assumes an open-drain bus from lwd_if and a master never faster than 400 kHz
//
// Summary of operation
// - hold sda low across the ninth clock
// - master clocks ack and releases sda
// - answer only address 0011011
// - read bit set: no ack, stay out
// - address with write, then sub-address byte
// - ack sub-address; data follows msb first
// - sub-address/data pairs repeat freely
// - data byte into holding latch at ack
// - valid stop copies all latches at once
// - keep pending data across foreign repeated starts
// - keep last complete set, drop partial
// - stop before data complete is ignored
// - pending data applied on a later stop unless an ignored stop has blocked it
// - after own re-address, stop waits for data
// - whole byte replaced on one ack
// - low three sub-address bits select register
// - works to 400 kHz, glitches filtered
`timescale 1ns/1ns
`include "lwd_defs.svh"
`default_nettype none
module lwd_slave_end
   import lwd_pkg::*;
#(
   parameter int FILT = `LWD_FILT_LEN
) (
   // clock and reset
   input  wire logic CLOCK,
   input  wire logic RSTN,
   // two-wire bus
   lwd_if.slave      BUS,
   // active registers
   output logic [7:0] RED_GREEN_LEVEL,
   output logic [7:0] BLUE_AUX_LEVEL,
   output logic [7:0] MAIN_LEVEL,
   output logic [7:0] SUB_LEVEL,
   output logic [7:0] AUX_MUX,
   output logic [7:0] CAMERA_HI_LO_LEVEL,
   output logic [7:0] OPTIONS,
   // status
   output logic       PENDING,
   output logic       UPDATED
);
   localparam int NR = `LWD_NUM_REGS;

   logic [1:0]      scl_sync_reg;
   logic [1:0]      sda_sync_reg;
   logic [FILT-1:0] scl_hist_reg;
   logic [FILT-1:0] sda_hist_reg;
   logic            scl_f_reg;
   logic            sda_f_reg;
   logic            scl_d_reg;
   logic            sda_d_reg;
   logic            scl_rise;
   logic            scl_fall;
   logic            start_ev;
   logic            stop_ev;

   lwd_slave_state_t   state_reg;
   lwd_kind_t          kind_reg;
   logic [3:0]         cnt_reg;
   logic [7:0]         shift_reg;
   logic [`LWD_SUB_BITS-1:0] sub_reg;
   logic               ack_oe_reg;
   logic               byte_end;
   logic               addr_match;
   logic               addr_ack_ev;
   logic               sub_ack_ev;
   logic               data_ack_ev;

   logic               addressed_reg;
   logic               complete_reg;
   logic               pending_reg;
   logic               block_reg;
   logic               apply_ev;
   logic               updated_reg;
   logic [7:0]         hold_reg [1:NR];
   logic [7:0]         act_reg  [1:NR];

   // first stage feeds only the second
   always_ff @(posedge CLOCK or negedge RSTN) begin
      if (!RSTN) begin
         scl_sync_reg <= 2'h3;
         sda_sync_reg <= 2'h3;
      end else begin
         scl_sync_reg <= {scl_sync_reg[0], BUS.scl};
         sda_sync_reg <= {sda_sync_reg[0], BUS.sda};
      end
   end

   // level changes only after FILT equal samples; both lines delayed alike
   always_ff @(posedge CLOCK or negedge RSTN) begin
      if (!RSTN) begin
         scl_hist_reg <= '1;
         sda_hist_reg <= '1;
         scl_f_reg    <= 1'b1;
         sda_f_reg    <= 1'b1;
         scl_d_reg    <= 1'b1;
         sda_d_reg    <= 1'b1;
      end else begin
         scl_hist_reg <= {scl_hist_reg[FILT-2:0], scl_sync_reg[1]};
         sda_hist_reg <= {sda_hist_reg[FILT-2:0], sda_sync_reg[1]};
         if (&scl_hist_reg || ~|scl_hist_reg) begin
            scl_f_reg <= scl_hist_reg[FILT-1];
         end
         if (&sda_hist_reg || ~|sda_hist_reg) begin
            sda_f_reg <= sda_hist_reg[FILT-1];
         end
         scl_d_reg <= scl_f_reg;
         sda_d_reg <= sda_f_reg;
      end
   end

   assign scl_rise = scl_f_reg && !scl_d_reg;
   assign scl_fall = !scl_f_reg && scl_d_reg;
   assign start_ev = scl_f_reg && scl_d_reg && !sda_f_reg && sda_d_reg;
   assign stop_ev  = scl_f_reg && scl_d_reg && sda_f_reg && !sda_d_reg;

   assign byte_end    = (state_reg == SS_BITS) && scl_fall && (cnt_reg == 4'h8);
   assign addr_match  = (shift_reg[7:1] == `LWD_SLAVE_ADDR) && !shift_reg[0];
   assign addr_ack_ev = byte_end && (kind_reg == BK_ADDR) && addr_match;
   assign sub_ack_ev  = byte_end && (kind_reg == BK_SUB);
   assign data_ack_ev = byte_end && (kind_reg == BK_DATA);

   // byte engine
   always_ff @(posedge CLOCK or negedge RSTN) begin
      if (!RSTN) begin
         state_reg  <= SS_IDLE;
         kind_reg   <= BK_ADDR;
         cnt_reg    <= 4'h0;
         shift_reg  <= 8'h00;
         ack_oe_reg <= 1'b0;
      end else if (start_ev) begin
         state_reg  <= SS_BITS;
         kind_reg   <= BK_ADDR;
         cnt_reg    <= 4'h0;
         ack_oe_reg <= 1'b0;
      end else if (stop_ev) begin
         state_reg  <= SS_IDLE;
         ack_oe_reg <= 1'b0;
      end else begin
         case (state_reg)
            SS_BITS: begin
               if (scl_rise && cnt_reg != 4'h8) begin
                  shift_reg <= {shift_reg[6:0], sda_f_reg};
                  cnt_reg   <= cnt_reg + 4'h1;
               end
               if (byte_end) begin
                  if (kind_reg == BK_ADDR && !addr_match) begin
                     state_reg <= SS_SKIP;
                  end else begin
                     state_reg  <= SS_ACK;
                     ack_oe_reg <= 1'b1;
                  end
               end
            end
            SS_ACK: begin
               // released on the falling edge that ends the ninth pulse
               if (scl_fall) begin
                  ack_oe_reg <= 1'b0;
                  state_reg  <= SS_BITS;
                  cnt_reg    <= 4'h0;
                  kind_reg   <= (kind_reg == BK_SUB) ? BK_DATA : BK_SUB;
               end
            end
            SS_SKIP: begin
               state_reg <= SS_SKIP;
            end
            default: begin
               state_reg <= SS_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge CLOCK or negedge RSTN) begin
      if (!RSTN) begin
         sub_reg <= '0;
      end else if (sub_ack_ev) begin
         sub_reg <= shift_reg[`LWD_SUB_BITS-1:0];
      end
   end

   // an ignored stop blocks updates until the next complete data byte
   assign apply_ev = stop_ev && pending_reg && !block_reg && !(addressed_reg && !complete_reg);

   always_ff @(posedge CLOCK or negedge RSTN) begin
      if (!RSTN) begin
         addressed_reg <= 1'b0;
         complete_reg  <= 1'b0;
         pending_reg   <= 1'b0;
         block_reg     <= 1'b0;
      end else begin
         if (start_ev || stop_ev) begin
            addressed_reg <= 1'b0;
            complete_reg  <= 1'b0;
         end else if (addr_ack_ev) begin
            addressed_reg <= 1'b1;
            complete_reg  <= 1'b0;
         end else if (sub_ack_ev) begin
            complete_reg  <= 1'b0;
         end else if (data_ack_ev) begin
            complete_reg  <= 1'b1;
         end
         if (data_ack_ev) begin
            pending_reg <= 1'b1;
            block_reg   <= 1'b0;
         end else if (apply_ev) begin
            pending_reg <= 1'b0;
         end
         if (stop_ev && addressed_reg && !complete_reg) begin
            block_reg <= 1'b1;
         end
      end
   end

   // holding latches and active copies
   always_ff @(posedge CLOCK or negedge RSTN) begin
      if (!RSTN) begin
         for (int i = 1; i <= NR; i++) begin
            hold_reg[i] <= `LWD_REG_RESET;
         end
      end else if (data_ack_ev && sub_reg != '0) begin
         hold_reg[sub_reg] <= shift_reg;
      end
   end

   always_ff @(posedge CLOCK or negedge RSTN) begin
      if (!RSTN) begin
         for (int i = 1; i <= NR; i++) begin
            act_reg[i] <= `LWD_REG_RESET;
         end
         updated_reg <= 1'b0;
      end else begin
         updated_reg <= apply_ev;
         if (apply_ev) begin
            for (int i = 1; i <= NR; i++) begin
               act_reg[i] <= hold_reg[i];
            end
         end
      end
   end

   assign BUS.s_sda_o        = 1'b0;
   assign BUS.s_sda_oe       = ack_oe_reg;
   assign RED_GREEN_LEVEL    = act_reg[1];
   assign BLUE_AUX_LEVEL     = act_reg[2];
   assign MAIN_LEVEL         = act_reg[3];
   assign SUB_LEVEL          = act_reg[4];
   assign AUX_MUX            = act_reg[5];
   assign CAMERA_HI_LO_LEVEL = act_reg[6];
   assign OPTIONS            = act_reg[7];
   assign PENDING            = pending_reg;
   assign UPDATED            = updated_reg;
endmodule : lwd_slave_end
`default_nettype wire

// ==== tb/lwd_link_checker.sv ====
// assertions on the two-wire bus between host end and device end
// assumes host QTR of at least 5 and bus lines driven from flops
`timescale 1ns/1ns
`default_nettype none
module lwd_link_checker (
   // clock and reset
   input wire logic CLOCK,
   input wire logic RSTN,
   // host drive
   input wire logic m_scl_o,
   input wire logic m_scl_oe,
   input wire logic m_sda_o,
   input wire logic m_sda_oe,
   // device drive
   input wire logic s_sda_o,
   input wire logic s_sda_oe,
   // resolved lines
   input wire logic scl,
   input wire logic sda
);
   logic       scl_d_reg;
   logic       sda_d_reg;
   logic [3:0] bit_cnt_reg;
   logic [3:0] byte_cnt_reg;
   logic [7:0] shift_reg;
   logic       addr_ok_reg;
   logic       start_seen;
   logic       stop_seen;
   logic       scl_rise;
   assign start_seen = scl && scl_d_reg && sda_d_reg && !sda;
   assign stop_seen  = scl && scl_d_reg && !sda_d_reg && sda;
   assign scl_rise   = scl && !scl_d_reg;
   default clocking cb @(posedge CLOCK); endclocking
   default disable iff (!RSTN);
   always_ff @(posedge CLOCK or negedge RSTN) begin
      if (!RSTN) begin
         scl_d_reg <= 1'b1;
         sda_d_reg <= 1'b1;
      end else begin
         scl_d_reg <= scl;
         sda_d_reg <= sda;
      end
   end
   // counts scl rises; the ninth pulse reads 9 while high
   always_ff @(posedge CLOCK or negedge RSTN) begin
      if (!RSTN) bit_cnt_reg <= 4'h0;
      else if (start_seen || stop_seen) bit_cnt_reg <= 4'h0;
      else if (scl_rise) bit_cnt_reg <= bit_cnt_reg + 4'h1;
      else if (!scl && scl_d_reg && bit_cnt_reg == 4'h9) bit_cnt_reg <= 4'h0;
   end
   // saturates so long transfers never wrap back to the address slot
   always_ff @(posedge CLOCK or negedge RSTN) begin
      if (!RSTN) byte_cnt_reg <= 4'h0;
      else if (start_seen) byte_cnt_reg <= 4'h0;
      else if (!scl && scl_d_reg && bit_cnt_reg == 4'h9 && byte_cnt_reg != 4'hf) byte_cnt_reg <= byte_cnt_reg + 4'h1;
   end
   always_ff @(posedge CLOCK or negedge RSTN) begin
      if (!RSTN) shift_reg <= 8'h00;
      else if (scl_rise) shift_reg <= {shift_reg[6:0], sda};
   end
   always_ff @(posedge CLOCK or negedge RSTN) begin
      if (!RSTN) addr_ok_reg <= 1'b0;
      else if (start_seen) addr_ok_reg <= 1'b0;
      else if (scl_rise && bit_cnt_reg == 4'h8 && byte_cnt_reg == 4'h0) addr_ok_reg <= s_sda_oe;
   end
   ack_stable_a: assert property (
      scl && $past(scl) |-> $stable(s_sda_oe)) else $error("device drive moved while scl high");
   addr_match_a: assert property (
      $rose(scl) && bit_cnt_reg == 4'h8 && byte_cnt_reg == 4'h0 |-> s_sda_oe == (shift_reg == 8'h36))
      else $error("address ack wrong");
   later_ack_a: assert property (
      $rose(scl) && bit_cnt_reg == 4'h8 && byte_cnt_reg != 4'h0 |-> s_sda_oe == addr_ok_reg)
      else $error("byte ack wrong");
   ack_rise_a: assert property (
      $fell(scl) && bit_cnt_reg == 4'h8 && (byte_cnt_reg == 4'h0 ? shift_reg == 8'h36 : addr_ok_reg)
      |-> ##[1:12] s_sda_oe) else $error("ack late");
   ack_release_a: assert property (
      $fell(scl) && bit_cnt_reg == 4'h9 |-> ##[1:12] !s_sda_oe) else $error("ack not released");
   ack_slot_a: assert property (
      s_sda_oe |-> bit_cnt_reg inside {4'h8, 4'h9} || (bit_cnt_reg == 4'h0 && !scl))
      else $error("device drove outside ack slot");
   host_release_a: assert property (
      scl && bit_cnt_reg == 4'h9 |-> !m_sda_oe) else $error("host held sda in ack slot");
   scl_high_a: assert property (
      $rose(scl) |=> scl [*8]) else $error("scl high too short");
endmodule : lwd_link_checker
`default_nettype wire

// ==== tb/testbench.sv ====
// top bench: host end writes device end; a bit-bang driver on a second bus breaks the protocol
// assumes hdl/ compiled first
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin n_fail++; \
   $display("[ERR] %s exp %0h got %0h", nm, e, g); end end
module testbench;
   localparam int QT = 10;
   logic        CLOCK;
   logic        RSTN;
   logic        wr_valid;
   logic        wr_ready;
   logic [7:0]  wr_sub;
   logic [7:0]  wr_data;
   logic [6:0]  tgt;
   logic        dir_rd;
   logic        busy;
   logic        nack;
   logic        pend;
   logic        pend2;
   logic        upd;
   logic [7:0]  ra [1:7];
   logic [7:0]  rb [1:7];
   logic [55:0] regs_now;
   logic [55:0] regs2_now;
   logic [55:0] regs_d;
   logic [7:0]  subs [10] = '{8'hf9, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07, 8'h00, 8'h0b, 8'h01};
   logic [7:0]  dats [10] = '{8'h5a, 8'hb2, 8'hc3, 8'hd4, 8'he5, 8'hf6, 8'h97, 8'hff, 8'h3c, 8'h1a};
   int          n_fail = 0;
   int          tests_run = 0;
   int          n_nack = 0;
   int          n_upd = 0;
   int          n_chg = 0;
   int          n_full = 0;
   lwd_if bus ();
   lwd_if bus2 ();
   lwd_host_end #(.QTR(QT)) lwd_host_end_i (.CLOCK(CLOCK), .RSTN(RSTN), .BUS(bus), .WR_VALID(wr_valid),
      .WR_READY(wr_ready), .WR_SUB(wr_sub), .WR_DATA(wr_data), .TARGET_ADDR(tgt), .DIR_READ(dir_rd),
      .BUSY(busy), .NACK(nack));
   lwd_slave_end lwd_slave_end_i (.CLOCK(CLOCK), .RSTN(RSTN), .BUS(bus), .RED_GREEN_LEVEL(ra[1]),
      .BLUE_AUX_LEVEL(ra[2]), .MAIN_LEVEL(ra[3]), .SUB_LEVEL(ra[4]), .AUX_MUX(ra[5]),
      .CAMERA_HI_LO_LEVEL(ra[6]), .OPTIONS(ra[7]), .PENDING(pend), .UPDATED(upd));
   // second device faces the bit-bang driver
   lwd_slave_end lwd_slave_end_i2 (.CLOCK(CLOCK), .RSTN(RSTN), .BUS(bus2), .RED_GREEN_LEVEL(rb[1]),
      .BLUE_AUX_LEVEL(rb[2]), .MAIN_LEVEL(rb[3]), .SUB_LEVEL(rb[4]), .AUX_MUX(rb[5]),
      .CAMERA_HI_LO_LEVEL(rb[6]), .OPTIONS(rb[7]), .PENDING(pend2), .UPDATED());
   lwd_link_checker lwd_link_checker_i (.CLOCK(CLOCK), .RSTN(RSTN), .m_scl_o(bus.m_scl_o),
      .m_scl_oe(bus.m_scl_oe), .m_sda_o(bus.m_sda_o), .m_sda_oe(bus.m_sda_oe), .s_sda_o(bus.s_sda_o),
      .s_sda_oe(bus.s_sda_oe), .scl(bus.scl), .sda(bus.sda));
   assign regs_now  = {ra[1], ra[2], ra[3], ra[4], ra[5], ra[6], ra[7]};
   assign regs2_now = {rb[1], rb[2], rb[3], rb[4], rb[5], rb[6], rb[7]};
   initial begin
      CLOCK = 1'b0;
      forever #4 CLOCK = ~CLOCK;
   end
   always @(posedge CLOCK) begin
      if (nack === 1'b1) n_nack++;
      if (upd === 1'b1) n_upd++;
      if (RSTN && regs_now !== regs_d) n_chg++;
      regs_d <= regs_now;
   end
   task automatic finish_test;
      $display("checks %0d mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : finish_test
   // valid stays high between words so no edge sees it lowered and raised
   task automatic push(input logic [7:0] s, input logic [7:0] d);
      int i;
      wr_valid <= 1'b1;
      wr_sub <= s;
      wr_data <= d;
      for (i = 0; i < 40000; i++) begin
         @(posedge CLOCK);
         if (wr_ready === 1'b1) break;
         n_full++;
      end
      if (i == 40000) begin
         n_fail++;
         finish_test();
      end
   endtask : push
   task automatic wait_idle;
      int i;
      wr_valid <= 1'b0;
      repeat (4) @(posedge CLOCK);
      for (i = 0; i < 60000 && busy !== 1'b0; i++) @(posedge CLOCK);
      if (i == 60000) begin
         n_fail++;
         finish_test();
      end
      repeat (30) @(posedge CLOCK);
   endtask : wait_idle
   task automatic bb(input logic c, input logic d);
      bus2.m_scl_oe <= !c;
      bus2.m_sda_oe <= !d;
      repeat (QT) @(posedge CLOCK);
   endtask : bb
   // pairs of scl,sda levels, first pair in the top bits
   task automatic bb_seq(input logic [7:0] p, input int n);
      for (int k = n - 1; k >= 0; k--) bb(p[2*k+1], p[2*k]);
   endtask : bb_seq
   task automatic bb_byte(input logic [7:0] b, input logic exp_ack);
      logic ack;
      for (int k = 7; k >= 0; k--) bb_seq({3'b000, b[k], 1'b1, b[k], 1'b0, b[k]}, 3);
      bb(1'b0, 1'b1);
      bb(1'b1, 1'b1);
      ack = !bus2.sda;
      bb(1'b0, 1'b1);
      `CHK("ack", exp_ack, ack)
   endtask : bb_byte
   initial begin
      RSTN = 1'b0;
      wr_valid = 1'b0;
      wr_sub = 8'h00;
      wr_data = 8'h00;
      tgt = 7'h1c;
      dir_rd = 1'b0;
      bus2.m_scl_o = 1'b0;
      bus2.m_sda_o = 1'b0;
      bus2.m_scl_oe = 1'b0;
      bus2.m_sda_oe = 1'b0;
      repeat (6) @(posedge CLOCK);
      RSTN <= 1'b1;
      repeat (2) @(posedge CLOCK);
      `CHK("regs", 56'h0, regs_now)
      `CHK("pend", 1'b0, pend)
      $display("test reset done");
      push(8'h03, 8'hee);
      wait_idle();
      tgt <= 7'h1b;
      dir_rd <= 1'b1;
      push(8'h03, 8'hee);
      wait_idle();
      dir_rd <= 1'b0;
      `CHK("nacks", 2, n_nack)
      `CHK("regs", 56'h0, regs_now)
      $display("test refused address done");
      n_chg = 0;
      for (int k = 0; k < 10; k++) push(subs[k], dats[k]);
      wait_idle();
      `CHK("refused", 1'b1, n_full > 0)
      `CHK("regs", 56'h1ab23cd4e5f697, regs_now)
      `CHK("updates", 1, n_upd)
      `CHK("changes", 1, n_chg)
      `CHK("pend", 1'b0, pend)
      $display("test burst done");
      bb_seq(8'h78, 4);
      bb_byte(8'h36, 1'b1);
      bb_byte(8'h03, 1'b1);
      bb_byte(8'h5a, 1'b1);
      bb(1'b0, 1'b0);
      bb(1'b1, 1'b0);
      // too short to be a stop
      bus2.m_sda_oe <= 1'b0;
      repeat (2) @(posedge CLOCK);
      bb(1'b1, 1'b0);
      `CHK("pend2", 1'b1, pend2)
      `CHK("regs2", 56'h0, regs2_now)
      bb_seq(8'h78, 4);
      bb_byte(8'h37, 1'b0);
      bb_seq(8'h78, 4);
      bb_byte(8'ha0, 1'b0);
      bb_byte(8'h55, 1'b0);
      bb_seq(8'h0b, 3);
      repeat (20) @(posedge CLOCK);
      `CHK("regs2", 56'h00005a00000000, regs2_now)
      $display("test foreign restart done");
      bb_seq(8'h78, 4);
      bb_byte(8'h36, 1'b1);
      bb_byte(8'h04, 1'b1);
      bb_byte(8'h11, 1'b1);
      bb_seq(8'h78, 4);
      bb_byte(8'h36, 1'b1);
      bb_byte(8'h05, 1'b1);
      bb_seq(8'h0b, 3);
      repeat (20) @(posedge CLOCK);
      `CHK("regs2", 56'h00005a00000000, regs2_now)
      `CHK("pend2", 1'b1, pend2)
      bb_seq(8'h78, 4);
      bb_seq(8'h0b, 3);
      repeat (20) @(posedge CLOCK);
      `CHK("regs2", 56'h00005a00000000, regs2_now)
      bb_seq(8'h78, 4);
      bb_byte(8'h36, 1'b1);
      bb_byte(8'h06, 1'b1);
      bb_byte(8'h77, 1'b1);
      bb_seq(8'h0b, 3);
      repeat (20) @(posedge CLOCK);
      `CHK("regs2", 56'h00005a11007700, regs2_now)
      `CHK("pend2", 1'b0, pend2)
      $display("test broken transfer done");
      finish_test();
   end
endmodule : testbench
`default_nettype wire
